// >>> dfmt_defs.vh
// constants for the disparity result formatter
// Operation
// - rectification happens upstream first; pixels arrive already rectified
// - in stereo mode each output word carries left image pixel and disparity
// - disparity is the left-view horizontal offset to the right image match
// - the depth matrix is sent with every disparity map
// - disparity is 12-bit unsigned, low 4 bits are the fraction
// - invalid disparities are sent as all-ones code 0xFFF
// - every image and disparity pair carries timestamp and sequence number
// - microsecond timestamp from trigger time or frame arrival, by selection
// - network-sourced pairs pass incoming timestamp and sequence unchanged
// - time server mode counts microseconds since the Unix epoch
// - without sync the clock starts at zero at power up
// - external sync mode clears the clock on each sync rising edge
// - sync between capture and output gives negative timestamp
// - sync input shares trigger 1 pin, active only with that trigger off
`ifndef DFMT_DEFS_VH
`define DFMT_DEFS_VH
`define DFMT_DISP_W      12
`define DFMT_FRAC_W      4
`define DFMT_PIX_W       8
`define DFMT_INVALID     12'hFFF
`define DFMT_TS_W        64
`define DFMT_SEQ_W       32
`define DFMT_Q_W         32
`define DFMT_Q_N         16
`define DFMT_Q_IDX_W     4
`define DFMT_CLK_HZ      25000000
`define DFMT_US_HZ       1000000
`define DFMT_US_DIV      (`DFMT_CLK_HZ / `DFMT_US_HZ)
`define DFMT_DIV_W       5
`define DFMT_FIFO_DEPTH  8
`define DFMT_SYNC_NONE   2'h0
`define DFMT_SYNC_EXT    2'h1
`define DFMT_SYNC_NTP    2'h2
`define DFMT_TS_TRIG     1'b0
`define DFMT_TS_ARRIVE   1'b1
`endif

// >>> dfmt_fifo.v
// synchronous valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module dfmt_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,     // clock
    input  wire             srst_i,    // sync reset
    input  wire             ce_i,      // clock enable
    input  wire [WIDTH-1:0] in_data_i, // write data
    input  wire             in_valid_i,// write request
    output wire             in_ready_o,// not full
    output wire [WIDTH-1:0] out_data_o,// head word
    output wire             out_valid_o,// not empty
    input  wire             out_ready_i // drain
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wp_q;
    reg [AW:0]      rp_q;
    wire            full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire            empty = (wp_q == rp_q);
    wire            wr    = ce_i && in_valid_i && !full;
    wire            rd    = ce_i && out_ready_i && !empty;
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rp_q[AW-1:0]];
    always @(posedge clk_i) begin
        if (wr) begin
            mem[wp_q[AW-1:0]] <= in_data_i;
        end
    end
    always @(posedge clk_i) begin
        if (srst_i) begin
            wp_q <= {(AW+1){1'b0}};
            rp_q <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule // dfmt_fifo
`default_nettype wire

// >>> dfmt_top.v
// disparity result formatter: timestamp clock, frame tagging and pixel output
`timescale 1ns/1ps
`default_nettype none
`include "dfmt_defs.vh"
module dfmt_top (
    input  wire                    core_clk_i,     // 25 MHz clock
    input  wire                    srst_i,         // sync reset, high
    input  wire                    ce_i,           // clock enable
    input  wire [1:0]              sync_mode_i,    // none/external/time server
    input  wire                    ts_src_i,       // 0 trigger time, 1 arrival
    input  wire                    trig1_en_i,     // trigger 1 output enabled
    input  wire                    trig1_drv_i,    // trigger 1 level to drive
    input  wire                    trig1_pin_i,    // shared pin, input side
    output wire                    trig1_pin_o,    // shared pin, output side
    output wire                    trig1_pin_oe_o, // shared pin drive enable
    input  wire                    ntp_load_i,     // load time server value
    input  wire [`DFMT_TS_W-1:0]   ntp_us_i,       // us since epoch
    input  wire                    trig_i,         // camera trigger generated
    input  wire                    frame_start_i,  // first pixel of a pair
    input  wire                    net_src_i,      // pair came from network
    input  wire [`DFMT_TS_W-1:0]   net_ts_i,       // incoming timestamp
    input  wire [`DFMT_SEQ_W-1:0]  net_seq_i,      // incoming sequence
    input  wire                    q_we_i,         // depth matrix write
    input  wire [`DFMT_Q_IDX_W-1:0] q_idx_i,       // matrix element index
    input  wire [`DFMT_Q_W-1:0]    q_data_i,       // matrix element value
    input  wire                    pix_valid_i,    // pixel valid
    output wire                    pix_ready_o,    // pixel accepted
    input  wire [`DFMT_PIX_W-1:0]  pix_left_i,     // rectified left pixel
    input  wire [`DFMT_DISP_W-1:0] pix_disp_i,     // 12-bit fixed disparity
    input  wire                    pix_bad_i,      // post-process rejected
    input  wire                    pix_last_i,     // last pixel of the pair
    output reg                     hdr_valid_o,    // header pulse
    output reg  [`DFMT_TS_W-1:0]   hdr_ts_o,       // signed timestamp
    output reg  [`DFMT_SEQ_W-1:0]  hdr_seq_o,      // sequence number
    output reg  [`DFMT_Q_N*`DFMT_Q_W-1:0] hdr_q_o, // depth matrix
    output wire                    out_valid_o,    // pixel word valid
    input  wire                    out_ready_i,    // client drain
    output wire [`DFMT_PIX_W-1:0]  out_left_o,     // left pixel
    output wire [`DFMT_DISP_W-1:0] out_disp_o,     // disparity
    output wire                    out_last_o      // end of pair
);
    localparam FW = `DFMT_PIX_W + `DFMT_DISP_W + 1;

    reg  [`DFMT_TS_W-1:0]  us_q;
    reg  [`DFMT_DIV_W-1:0] div_q;
    reg                    sync_s0_q;
    reg                    sync_s1_q;
    reg                    sync_s2_q;
    reg  [`DFMT_TS_W-1:0]  trig_ts_q;
    reg                    trig_hit_q;
    reg  [`DFMT_TS_W-1:0]  trig_gap_q;
    reg  [`DFMT_TS_W-1:0]  cap_ts_q;
    reg                    sync_hit_q;
    reg  [`DFMT_TS_W-1:0]  at_sync_q;
    reg  [`DFMT_SEQ_W-1:0] seq_q;
    reg  [`DFMT_Q_W-1:0]   q_mem [0:`DFMT_Q_N-1];
    reg                    in_frame_q;
    reg                    hdr_pend_q;
    integer                k;

    wire ext_sync  = (sync_mode_i == `DFMT_SYNC_EXT) && !trig1_en_i;
    wire sync_rise = ext_sync && sync_s1_q && !sync_s2_q;
    wire us_tick   = (div_q == `DFMT_US_DIV - 1);
    wire [`DFMT_TS_W-1:0] ts_pick = (ts_src_i == `DFMT_TS_ARRIVE) ? us_q : trig_ts_q;

    // pin drives only while trigger 1 is on; otherwise it is the sync input
    assign trig1_pin_o    = trig1_drv_i;
    assign trig1_pin_oe_o = trig1_en_i;

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            sync_s0_q <= 1'b0;
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
        end else if (ce_i) begin
            sync_s0_q <= trig1_pin_i;
            sync_s1_q <= sync_s0_q;
            sync_s2_q <= sync_s1_q;
        end
    end

    // microsecond clock; cleared at reset when no sync source loads it
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            us_q  <= {`DFMT_TS_W{1'b0}};
            div_q <= {`DFMT_DIV_W{1'b0}};
        end else if (ce_i) begin
            if (sync_rise) begin
                us_q  <= {`DFMT_TS_W{1'b0}};
                div_q <= {`DFMT_DIV_W{1'b0}};
            end else if (ntp_load_i && sync_mode_i == `DFMT_SYNC_NTP) begin
                us_q  <= ntp_us_i;
                div_q <= {`DFMT_DIV_W{1'b0}};
            end else if (us_tick) begin
                us_q  <= us_q + 1'b1;
                div_q <= {`DFMT_DIV_W{1'b0}};
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

    // capture time of the pending pair, tracking sync edges until it leaves
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            trig_ts_q  <= {`DFMT_TS_W{1'b0}};
            trig_hit_q <= 1'b0;
            trig_gap_q <= {`DFMT_TS_W{1'b0}};
            cap_ts_q   <= {`DFMT_TS_W{1'b0}};
            sync_hit_q <= 1'b0;
            at_sync_q  <= {`DFMT_TS_W{1'b0}};
        end else if (ce_i) begin
            // a sync edge while waiting for the frame of a trigger also counts
            if (trig_i) begin
                trig_ts_q  <= us_q;
                trig_hit_q <= 1'b0;
            end else if (sync_rise) begin
                trig_hit_q <= 1'b1;
                trig_gap_q <= trig_hit_q ? trig_gap_q + us_q : us_q - trig_ts_q;
            end
            if (frame_start_i && !in_frame_q) begin
                cap_ts_q <= ts_pick;
                if (ts_src_i == `DFMT_TS_TRIG && trig_hit_q) begin
                    sync_hit_q <= 1'b1;
                    at_sync_q  <= trig_gap_q;
                end else begin
                    sync_hit_q <= 1'b0;
                end
            end else if (sync_rise) begin
                // clock restarted at the last edge, so intervals accumulate
                sync_hit_q <= 1'b1;
                at_sync_q  <= sync_hit_q ? at_sync_q + us_q : us_q - cap_ts_q;
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (q_we_i && ce_i) begin
            q_mem[q_idx_i] <= q_data_i;
        end
    end

    wire fifo_ready;
    wire take = pix_valid_i && fifo_ready && ce_i;
    assign pix_ready_o = fifo_ready;

    // header pulse two cycles after pair start is seen; pixels stream through the fifo independently
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            seq_q       <= {`DFMT_SEQ_W{1'b0}};
            in_frame_q  <= 1'b0;
            hdr_pend_q  <= 1'b0;
            hdr_valid_o <= 1'b0;
            hdr_ts_o    <= {`DFMT_TS_W{1'b0}};
            hdr_seq_o   <= {`DFMT_SEQ_W{1'b0}};
            hdr_q_o     <= {(`DFMT_Q_N*`DFMT_Q_W){1'b0}};
        end else if (ce_i) begin
            hdr_valid_o <= 1'b0;
            if (frame_start_i && !in_frame_q) begin
                in_frame_q <= 1'b1;
                hdr_pend_q <= 1'b1;
            end
            if (hdr_pend_q) begin
                hdr_pend_q  <= 1'b0;
                hdr_valid_o <= 1'b1;
                for (k = 0; k < `DFMT_Q_N; k = k + 1) begin
                    hdr_q_o[k*`DFMT_Q_W +: `DFMT_Q_W] <= q_mem[k];
                end
                if (net_src_i) begin
                    hdr_ts_o  <= net_ts_i;
                    hdr_seq_o <= net_seq_i;
                end else begin
                    hdr_ts_o  <= sync_hit_q ? (~at_sync_q + 1'b1) : cap_ts_q;
                    hdr_seq_o <= seq_q;
                    seq_q     <= seq_q + 1'b1;
                end
            end
            if (take && pix_last_i) begin
                in_frame_q <= 1'b0;
            end
        end
    end

    // upstream delivers rectified, left-view horizontal disparities
    wire [`DFMT_DISP_W-1:0] disp_enc = pix_bad_i ? `DFMT_INVALID : pix_disp_i;
    wire [FW-1:0]           fifo_out;

    dfmt_fifo #(
        .WIDTH (FW),
        .DEPTH (`DFMT_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clk_i       (core_clk_i),
        .srst_i      (srst_i),
        .ce_i        (ce_i),
        .in_data_i   ({pix_last_i, pix_left_i, disp_enc}),
        .in_valid_i  (pix_valid_i),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i)
    );

    assign out_disp_o = fifo_out[`DFMT_DISP_W-1:0];
    assign out_left_o = fifo_out[`DFMT_DISP_W +: `DFMT_PIX_W];
    assign out_last_o = fifo_out[FW-1];
endmodule // dfmt_top
`default_nettype wire

// >>> dfmt_client.sv
// client model: drains output words, slows to three in four, stalls on demand
`timescale 1ns/1ps
`default_nettype none
module dfmt_client (
    input  wire logic        clk_i,   // clock
    input  wire logic        stall_i, // hold off
    input  wire logic        valid_i, // word offered
    input  wire logic [20:0] word_i,  // last, disparity, left
    output logic             ready_o  // drain
);
    logic [20:0] got[$];
    logic [1:0]  ph_q = 2'h0;
    wire  [7:0]  disp_px = word_i[19:12];
    assign ready_o = !stall_i && ph_q != 2'h3;
    always @(posedge clk_i) begin
        ph_q <= ph_q + 2'h1;
        if (valid_i && ready_o) got.push_back(word_i);
    end
endmodule // dfmt_client
`default_nettype wire

// >>> dfmt_sva.sv
// assertions on the formatter top ports
`timescale 1ns/1ps
`default_nettype none
module dfmt_sva (
    input wire logic         core_clk_i, srst_i, ce_i,                    // clock
    input wire logic         trig1_en_i, trig1_drv_i, trig1_pin_o, trig1_pin_oe_o, // pin
    input wire logic         frame_start_i, net_src_i, hdr_valid_o, out_valid_o, // strobes
    input wire logic         pix_valid_i, pix_ready_o, pix_last_i,        // pixel in
    input wire logic [63:0]  net_ts_i, hdr_ts_o,                          // times
    input wire logic [31:0]  net_seq_i, hdr_seq_o,                        // sequence
    input wire logic [511:0] hdr_q_o                                      // matrix
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic        open_q, seen_q;
    logic [31:0] cam_q;
    wire         take = ce_i && pix_valid_i && pix_ready_o;
    wire         go = ce_i && frame_start_i && !open_q;
    always @(posedge core_clk_i)
        open_q <= srst_i ? 1'b0 : go ? 1'b1 : (take && pix_last_i) ? 1'b0 : open_q;
    // tracks the last camera sequence; network pairs leave it alone
    always @(posedge core_clk_i)
        if (srst_i) seen_q <= 1'b0;
        else if (hdr_valid_o && !$past(net_src_i)) {seen_q, cam_q} <= {1'b1, hdr_seq_o};
    sequence s_start; go; endsequence
    sequence s_pulse; !hdr_valid_o [*2] ##1 hdr_valid_o ##1 !hdr_valid_o; endsequence
    chk_hdr_time: assert property (s_start |-> s_pulse)
        else $error("header timing");
    chk_start_busy: assert property (frame_start_i && open_q |-> ##2 !hdr_valid_o)
        else $error("start inside pair");
    chk_seq_step: assert property (hdr_valid_o && !$past(net_src_i)
        |-> hdr_seq_o == (seen_q ? cam_q + 32'h1 : 32'h0)) else $error("sequence step");
    chk_net_copy: assert property (hdr_valid_o && $past(net_src_i)
        |-> hdr_ts_o == $past(net_ts_i) && hdr_seq_o == $past(net_seq_i)) else $error("copy");
    chk_hdr_stand: assert property (!hdr_valid_o |-> $stable({hdr_ts_o, hdr_seq_o, hdr_q_o}))
        else $error("header moved");
    chk_out_fill: assert property (take |=> out_valid_o)
        else $error("word not offered");
    chk_pin_oe: assert property (trig1_pin_oe_o == trig1_en_i)
        else $error("pin enable");
    chk_pin_lvl: assert property (trig1_pin_oe_o |-> trig1_pin_o == trig1_drv_i)
        else $error("pin level");
endmodule // dfmt_sva
bind dfmt_top dfmt_sva dfmt_sva_i (.*);
`default_nettype wire

// >>> dfmt_top_tb.sv
// self-checking bench for the disparity result formatter
`timescale 1ns/1ps
`default_nettype none
module dfmt_top_tb;
    logic core_clk_i = '0, srst_i = '1, ce_i = '1, ts_src_i = '0, trig1_en_i = '0;
    logic trig1_drv_i = '0, ntp_load_i = '0, trig_i = '0, frame_start_i = '0, net_src_i = '0;
    logic q_we_i = '0, pix_valid_i = '0, pix_bad_i = '0, pix_last_i = '0, pin_in = '0, stall = '0;
    logic [1:0]  sync_mode_i = '0;
    logic [3:0]  q_idx_i = '0;
    logic [7:0]  pix_left_i = '0;
    logic [11:0] pix_disp_i = '0;
    logic [31:0] net_seq_i = '0, q_data_i = '0;
    logic [63:0] ntp_us_i = '0, net_ts_i = '0;
    wire trig1_pin_o, trig1_pin_oe_o, pix_ready_o, hdr_valid_o, out_valid_o, out_ready_i;
    wire out_last_o;
    wire [7:0] out_left_o;
    wire [11:0] out_disp_o;
    wire [31:0] hdr_seq_o;
    wire [63:0] hdr_ts_o;
    wire [511:0] hdr_q_o;
    wire trig1_pin_i = trig1_pin_oe_o ? trig1_pin_o : pin_in;
    int n_mismatch = 0, cmp_count = 0;
    always #20 core_clk_i = ~core_clk_i;
    dfmt_top dfmt_top_i (.*);
    dfmt_client dfmt_client_i (.clk_i(core_clk_i), .stall_i(stall), .valid_i(out_valid_o),
        .word_i({out_last_o, out_disp_o, out_left_o}), .ready_o(out_ready_i));
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic chk(input logic [63:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic hang(input int k, lim);
        if (k >= lim) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic pulse_trig;
        trig_i = 1'b1;
        tick(1);
        trig_i = 1'b0;
    endtask
    // one pair: header, then n pixels, every fourth rejected, a stray start at pixel 1
    task automatic frame(input logic net, input int n, input logic [63:0] lo, hi, seq);
        int k;
        net_src_i = net;
        frame_start_i = 1'b1;
        tick(1);
        frame_start_i = 1'b0;
        tick(1);
        chk(64'(hdr_valid_o), 64'h1);
        chk(64'($signed(hdr_ts_o) >= $signed(lo) && $signed(hdr_ts_o) <= $signed(hi)), 64'h1);
        chk(64'(hdr_seq_o), seq);
        for (int i = 0; i < 16; i++) chk(64'(hdr_q_o[i*32+:32]), 64'(32'h1000 + i));
        pix_valid_i = 1'b1;
        for (int i = 0; i < n; i++) begin
            {pix_left_i, pix_disp_i, pix_bad_i} = {8'hA0 + 8'(i), 8'(i), 4'h5, i % 4 == 3};
            pix_last_i = (i == n - 1);
            frame_start_i = (i == 1);
            // stalled client: eight words fill the buffer
            if (stall && i == 8) chk(64'(pix_ready_o), 64'h0);
            if (i == 8) stall = 1'b0;
            for (k = 0; k < 99 && pix_ready_o !== 1'b1; k++) tick(1);
            hang(k, 99);
            tick(1);
        end
        pix_valid_i = 1'b0;
        for (k = 0; k < 499 && dfmt_client_i.got.size() < n; k++) tick(1);
        hang(k, 499);
        for (int i = 0; i < n; i++) chk(64'(dfmt_client_i.got.pop_front()),
            64'({i == n - 1, i % 4 == 3 ? 12'hFFF : {8'(i), 4'h5}, 8'hA0 + 8'(i)}));
    endtask
    task automatic boot_pair;
        for (int i = 0; i < 16; i++) begin
            {q_we_i, q_idx_i, q_data_i} = {1'b1, 4'(i), 32'h1000 + 32'(i)};
            tick(1);
        end
        q_we_i = 1'b0;
        tick(100);
        pulse_trig();
        stall = 1'b1;
        frame(1'b0, 10, 64'h3, 64'h6, 64'h0);
    endtask
    task automatic seq_pairs;
        pulse_trig();
        frame(1'b0, 4, 64'h0, 64'h63, 64'h1);
        {net_ts_i, net_seq_i} = {64'h0123456789ABCDEF, 32'h00000AB0};
        frame(1'b1, 4, net_ts_i, net_ts_i, 64'(net_seq_i));
        pulse_trig();
        frame(1'b0, 4, 64'h0, 64'h63, 64'h2);
    endtask
    task automatic sync_pairs;
        {sync_mode_i, trig1_en_i, trig1_drv_i} = {2'h1, 1'b1, 1'b1};
        tick(1);
        chk(64'({trig1_pin_oe_o, trig1_pin_o}), 64'h3);
        {trig1_en_i, trig1_drv_i} = 2'h0;
        tick(2);
        pin_in = 1'b1;
        tick(250);
        pulse_trig();
        frame(1'b0, 4, 64'h9, 64'hB, 64'h3);
        pin_in = 1'b0;
        pulse_trig();
        tick(50);
        pin_in = 1'b1;
        tick(10);
        frame(1'b0, 4, -64'sh3, -64'sh1, 64'h4);
    endtask
    task automatic ntp_pair(input logic src, input logic [63:0] off, seq);
        {sync_mode_i, ts_src_i, ntp_us_i} = {2'h2, src, 64'h0005800000000000};
        ntp_load_i = 1'b1;
        tick(1);
        ntp_load_i = 1'b0;
        pulse_trig();
        tick(250);
        frame(1'b0, 4, ntp_us_i + off, ntp_us_i + off + 64'h2, seq);
    endtask
    initial begin
        tick(6);
        srst_i = 1'b0;
        boot_pair();
        seq_pairs();
        sync_pairs();
        ntp_pair(1'b0, 64'h0, 64'h5);
        ntp_pair(1'b1, 64'h9, 64'h6);
        complete_run();
    end
endmodule // dfmt_top_tb
`default_nettype wire
